// *** tio_pkg.sv ***
package tio_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TICK_MS      = 1;        // time base period, ms
  localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000 * TICK_MS;
  localparam logic [5:0]  IN_WIDTH_DEF = 6'h05;    // 5 ms when width field is 0
  localparam logic [5:0]  WIDTH_MAX    = 6'h3c;    // 60 ms
  localparam logic [15:0] FSET_MIN     = 16'h1194; // 45.00 Hz in 0.01 Hz
  localparam logic [15:0] FSET_MAX     = 16'hc350; // 500.00 Hz in 0.01 Hz
  localparam logic [15:0] FSET_RST     = 16'h1388; // 50.00 Hz
  localparam logic [3:0]  SLOT_MAX     = 4'h9;     // presets zero to nine
  // register byte offsets
  localparam logic [7:0]  OFS_IN_CFG   = 8'h00;
  localparam logic [7:0]  OFS_SETPT    = 8'h04;
  localparam logic [7:0]  OFS_OUT_CFG  = 8'h08;
  localparam logic [7:0]  OFS_CMD_STAT = 8'h0c;
  // field positions
  localparam int unsigned IN_ACT_LSB   = 0;
  localparam int unsigned IN_STATE_BIT = 4;
  localparam int unsigned IN_SLOT_LSB  = 8;
  localparam int unsigned IN_WID_LSB   = 16;
  localparam int unsigned SP_V_LSB     = 0;
  localparam int unsigned SP_F_LSB     = 16;
  localparam int unsigned OUT_SRC_LSB  = 0;
  localparam int unsigned OUT_LVL_BIT  = 4;
  localparam int unsigned OUT_WID_LSB  = 8;
  localparam int unsigned CMD_IN_BIT   = 0;
  localparam int unsigned CMD_OUT_BIT  = 1;
  localparam int unsigned ST_PIN_BIT   = 8;
  localparam int unsigned ST_OUT_BIT   = 9;
  localparam int unsigned ST_TEST_BIT  = 10;
  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  typedef enum logic [2:0] {
    TIO_ACT_NONE    = 3'b000,
    TIO_ACT_OUTPUT  = 3'b001,
    TIO_ACT_SETTING = 3'b010,
    TIO_ACT_PRESET  = 3'b011,
    TIO_ACT_TRANS   = 3'b100
  } tio_action_t;

  typedef enum logic [2:0] {
    TIO_SRC_NONE    = 3'b000,
    TIO_SRC_OUTPUT  = 3'b001,
    TIO_SRC_SETTING = 3'b010,
    TIO_SRC_PRESET  = 3'b011,
    TIO_SRC_ALL     = 3'b100
  } tio_source_t;

  // instrument events, one-cycle pulses or held levels
  typedef struct packed {
    logic output_chg;
    logic setting_chg;
    logic preset_load;
    logic preset_save;
  } tio_ev_t;

  // actions issued toward the instrument
  typedef struct packed {
    logic        out_set;
    logic        out_state;
    logic        sp_apply;
    logic [15:0] vset;
    logic [15:0] fset;
    logic        pre_load;
    logic [3:0]  slot;
    logic        transient_event_action;
    logic        remote_trig;
  } tio_cmd_t;

  // clamp a width to 60 ms
  function automatic logic [5:0] clamp_width(input logic [5:0] w);
    clamp_width = (w > WIDTH_MAX) ? WIDTH_MAX : w;
  endfunction : clamp_width
endpackage : tio_pkg

// *** tio_ms_tick.sv ***
`timescale 1ns/10ps
module tio_ms_tick #(
  parameter int unsigned MS_CYCLES = tio_pkg::CYC_PER_MS
) (
  input  wire logic clk_i,   // system clock
  input  wire logic rst_n_i, // async reset, low
  output logic      tick_o   // one-cycle pulse each ms
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tio_tick_st_t;

  tio_tick_st_t st_reg;
  tio_tick_st_t st_next;

  // free running divider
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 16'(MS_CYCLES - 1)) begin
      st_next.cnt  = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_reg <= '0;
    else          st_reg <= st_next;
  end

  assign tick_o = st_reg.tick;
endmodule : tio_ms_tick

// *** tio_in_qual.sv ***
`timescale 1ns/10ps
module tio_in_qual (
  input  wire logic       clk_i,      // system clock
  input  wire logic       rst_n_i,    // async reset, low
  input  wire logic       pin_i,      // raw trigger input pin
  input  wire logic       tick_i,     // ms tick
  input  wire logic [5:0] width_ms_i, // effective minimum width
  output logic            level_o,    // filtered pin level
  output logic            pulse_o     // one-cycle qualified trigger
);
  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic [6:0] hi_ms;
    logic       fired;
    logic       pulse;
  } tio_qual_st_t;

  tio_qual_st_t st_reg;
  tio_qual_st_t st_next;

  // three-stage sync, level moves only when stages two and three agree
  always_comb begin
    st_next       = st_reg;
    st_next.pulse = 1'b0;
    st_next.sync  = {st_reg.sync[1:0], pin_i};               // [R18]
    if (st_reg.sync[1] == st_reg.sync[2]) st_next.level = st_reg.sync[2];
    if (!st_reg.level) begin                                  // [R2]
      st_next.hi_ms = 7'h00;
      st_next.fired = 1'b0;
    end else if (tick_i && !st_reg.fired) begin
      // one extra tick covers the unknown tick phase at the rising edge
      if (st_reg.hi_ms == {1'b0, width_ms_i}) begin           // [R8]
        st_next.fired = 1'b1;
        st_next.pulse = 1'b1;
      end else begin
        st_next.hi_ms = st_reg.hi_ms + 7'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) st_reg <= '0;
    else          st_reg <= st_next;
  end

  assign level_o = st_reg.level;
  assign pulse_o = st_reg.pulse;
endmodule : tio_in_qual

// *** tio_trigger_io.sv ***
// Functional notes
// [R1] simulation or sequence mode ignores trigger config
// [R2] input triggers only when pin is high
// [R3] action none: no effect, remote trigger accepted
// [R4] action output: force output to chosen state
// [R5] action setting: apply voltage and clamped frequency
// [R6] action preset: load chosen slot zero to nine
// [R7] action surge/dip: request transient event start
// [R8] input must stay high minimum width
// [R9] source none: no events, remote still works
// [R10] source output: activate on output on/off
// [R11] source setting: activate on setting change
// [R12] source preset: activate on load or save
// [R13] source all: activate on any event
// [R14] width 1..60 ms gives exact pulse
// [R15] width 0 gives static level, chosen polarity
// [R16] polarity ignored in pulse width mode
// [R17] new event restarts running output pulse
// [R18] ms tick timing and synchronised input pin
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module tio_trigger_io #(
  parameter int unsigned MS_CYCLES = tio_pkg::CYC_PER_MS
) (
  input  wire logic             clk_i,       // system clock, 10 MHz
  input  wire logic             rst_n_i,     // async reset, low
  input  wire logic             hsel,        // ahb slave select
  input  wire logic [31:0]      haddr,       // ahb address
  input  wire logic [1:0]       htrans,      // ahb transfer type
  input  wire logic             hwrite,      // ahb write
  input  wire logic [2:0]       hsize,       // ahb size
  input  wire logic [31:0]      hwdata,      // ahb write data
  input  wire logic             hready,      // ahb bus ready
  output logic                  hreadyout,   // ahb slave ready
  output logic [31:0]           hrdata,      // ahb read data
  output logic                  hresp,       // ahb response, always okay
  input  wire logic             trig_in_i,   // trigger input pin
  output logic                  trig_out_o,  // trigger output pin
  input  wire logic             test_mode_i, // simulation or sequence running
  input  wire tio_pkg::tio_ev_t ev_i,        // instrument events
  output tio_pkg::tio_cmd_t     cmd_o        // actions to the instrument
);
  typedef struct packed {
    logic [2:0]  in_action;
    logic        in_state;
    logic [3:0]  in_slot;
    logic [5:0]  in_width;
    logic [15:0] vset;
    logic [15:0] fset;
    logic [2:0]  out_source;
    logic        out_level_hi;
    logic [5:0]  out_width;
    logic        d_write;
    logic [7:0]  d_addr;
    logic [31:0] rdata;
    logic        pulse_on;
    logic [5:0]  pulse_ms;
    logic [15:0] pulse_sub;
    logic        pin;
    tio_pkg::tio_cmd_t cmd;
  } tio_st_t;

  tio_st_t     st_reg;
  tio_st_t     st_next;
  logic        tick;
  logic        in_level;
  logic        in_pulse;
  logic [5:0]  in_width_eff;
  logic        addr_ok;
  logic        sw_in_trig;
  logic        sw_out_trig;
  logic        src_hit;
  logic        src_level;
  logic [31:0] rd_mux;

  tio_ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  // zero selects the default 5 ms minimum
  assign in_width_eff = (st_reg.in_width == 6'h00) ? tio_pkg::IN_WIDTH_DEF
                                                  : st_reg.in_width; // [R8]

  tio_in_qual u_qual (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (trig_in_i),
    .tick_i     (tick),
    .width_ms_i (in_width_eff),
    .level_o    (in_level),
    .pulse_o    (in_pulse)
  );

  // address phase qualifier, zero wait state slave
  assign addr_ok = hsel && hready &&
                   (htrans == tio_pkg::HTRANS_NONSEQ || htrans == tio_pkg::HTRANS_SEQ);

  // command strobes from a write data phase
  assign sw_in_trig  = st_reg.d_write && st_reg.d_addr == tio_pkg::OFS_CMD_STAT &&
                       hwdata[tio_pkg::CMD_IN_BIT];
  assign sw_out_trig = st_reg.d_write && st_reg.d_addr == tio_pkg::OFS_CMD_STAT &&
                       hwdata[tio_pkg::CMD_OUT_BIT];

  // source selection, used both as a pulse restart on every active cycle and as level for width 0
  always_comb begin
    case (tio_pkg::tio_source_t'(st_reg.out_source))
      tio_pkg::TIO_SRC_NONE:    src_hit = 1'b0;                                    // [R9]
      tio_pkg::TIO_SRC_OUTPUT:  src_hit = ev_i.output_chg;                         // [R10]
      tio_pkg::TIO_SRC_SETTING: src_hit = ev_i.setting_chg;                        // [R11]
      tio_pkg::TIO_SRC_PRESET:  src_hit = ev_i.preset_load | ev_i.preset_save;     // [R12]
      tio_pkg::TIO_SRC_ALL:     src_hit = |ev_i;                                   // [R13]
      default:                  src_hit = 1'b0;
    endcase
    src_level = src_hit && !test_mode_i;                                           // [R1]
  end

  // read mux, captured at address phase so hrdata leaves a flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      tio_pkg::OFS_IN_CFG: begin
        rd_mux[tio_pkg::IN_ACT_LSB +: 3]  = st_reg.in_action;
        rd_mux[tio_pkg::IN_STATE_BIT]     = st_reg.in_state;
        rd_mux[tio_pkg::IN_SLOT_LSB +: 4] = st_reg.in_slot;
        rd_mux[tio_pkg::IN_WID_LSB +: 6]  = st_reg.in_width;
      end
      tio_pkg::OFS_SETPT: begin
        rd_mux[tio_pkg::SP_V_LSB +: 16] = st_reg.vset;
        rd_mux[tio_pkg::SP_F_LSB +: 16] = st_reg.fset;
      end
      tio_pkg::OFS_OUT_CFG: begin
        rd_mux[tio_pkg::OUT_SRC_LSB +: 3] = st_reg.out_source;
        rd_mux[tio_pkg::OUT_LVL_BIT]      = st_reg.out_level_hi;
        rd_mux[tio_pkg::OUT_WID_LSB +: 6] = st_reg.out_width;
      end
      tio_pkg::OFS_CMD_STAT: begin
        rd_mux[tio_pkg::ST_PIN_BIT]  = in_level;
        rd_mux[tio_pkg::ST_OUT_BIT]  = st_reg.pin;
        rd_mux[tio_pkg::ST_TEST_BIT] = test_mode_i;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // next state: bus, input action, output pin
  always_comb begin
    st_next = st_reg;
    st_next.cmd.out_set                = 1'b0;
    st_next.cmd.sp_apply               = 1'b0;
    st_next.cmd.pre_load               = 1'b0;
    st_next.cmd.transient_event_action = 1'b0;
    st_next.cmd.remote_trig            = 1'b0;

    // bus address phase
    st_next.d_write = addr_ok && hwrite;
    if (addr_ok) begin
      st_next.d_addr = haddr[7:0];
      st_next.rdata  = hwrite ? 32'h0000_0000 : rd_mux;
    end

    // bus data phase writes; out-of-range slot, width and frequency values clamp to the legal range
    if (st_reg.d_write) begin
      case (st_reg.d_addr)
        tio_pkg::OFS_IN_CFG: begin
          st_next.in_action = hwdata[tio_pkg::IN_ACT_LSB +: 3];
          st_next.in_state  = hwdata[tio_pkg::IN_STATE_BIT];
          st_next.in_slot   = (hwdata[tio_pkg::IN_SLOT_LSB +: 4] > tio_pkg::SLOT_MAX)
                              ? tio_pkg::SLOT_MAX
                              : hwdata[tio_pkg::IN_SLOT_LSB +: 4];                  // [R6]
          st_next.in_width  = tio_pkg::clamp_width(hwdata[tio_pkg::IN_WID_LSB +: 6]); // [R8]
        end
        tio_pkg::OFS_SETPT: begin
          st_next.vset = hwdata[tio_pkg::SP_V_LSB +: 16];
          if (hwdata[tio_pkg::SP_F_LSB +: 16] < tio_pkg::FSET_MIN)
            st_next.fset = tio_pkg::FSET_MIN;                                      // [R5]
          else if (hwdata[tio_pkg::SP_F_LSB +: 16] > tio_pkg::FSET_MAX)
            st_next.fset = tio_pkg::FSET_MAX;                                      // [R5]
          else
            st_next.fset = hwdata[tio_pkg::SP_F_LSB +: 16];
        end
        tio_pkg::OFS_OUT_CFG: begin
          st_next.out_source   = hwdata[tio_pkg::OUT_SRC_LSB +: 3];
          st_next.out_level_hi = hwdata[tio_pkg::OUT_LVL_BIT];
          st_next.out_width    = tio_pkg::clamp_width(hwdata[tio_pkg::OUT_WID_LSB +: 6]);
        end
        default: ;
      endcase
    end

    // remote trigger is always accepted, whatever the action setting
    st_next.cmd.remote_trig = sw_in_trig;                                          // [R3]

    // qualified pin pulse runs the selected action, not in test modes
    if (in_pulse && !test_mode_i) begin                                            // [R1]
      case (tio_pkg::tio_action_t'(st_reg.in_action))
        tio_pkg::TIO_ACT_NONE: ;                                                   // [R3]
        tio_pkg::TIO_ACT_OUTPUT: begin
          st_next.cmd.out_set   = 1'b1;                                            // [R4]
          st_next.cmd.out_state = st_reg.in_state;
        end
        tio_pkg::TIO_ACT_SETTING: begin
          st_next.cmd.sp_apply = 1'b1;                                             // [R5]
          st_next.cmd.vset     = st_reg.vset;
          st_next.cmd.fset     = st_reg.fset;
        end
        tio_pkg::TIO_ACT_PRESET: begin
          st_next.cmd.pre_load = 1'b1;                                             // [R6]
          st_next.cmd.slot     = st_reg.in_slot;
        end
        tio_pkg::TIO_ACT_TRANS: st_next.cmd.transient_event_action = 1'b1;         // [R7]
        default: ;
      endcase
    end

    // output pulse timer: cycle-exact, so restarts are not tied to the tick
    if (st_reg.out_width != 6'h00 && ((src_level) || sw_out_trig)) begin
      st_next.pulse_on  = 1'b1;                                                    // [R17]
      st_next.pulse_ms  = st_reg.out_width;
      st_next.pulse_sub = 16'(MS_CYCLES - 1);
    end else if (st_reg.pulse_on) begin
      if (st_reg.pulse_sub != 16'h0000) begin
        st_next.pulse_sub = st_reg.pulse_sub - 16'h0001;
      end else if (st_reg.pulse_ms == 6'h01) begin
        st_next.pulse_on = 1'b0;                                                   // [R14]
      end else begin
        st_next.pulse_ms  = st_reg.pulse_ms - 6'h01;
        st_next.pulse_sub = 16'(MS_CYCLES - 1);
      end
    end
    if (st_reg.out_width == 6'h00) st_next.pulse_on = 1'b0;

    // pin: pulse high in width mode, polarity only in static mode
    if (st_reg.out_width != 6'h00)
      st_next.pin = st_next.pulse_on;                                              // [R16]
    else if (test_mode_i)
      st_next.pin = 1'b0;                                                          // [R1]
    else
      st_next.pin = (src_level || sw_out_trig) ? st_reg.out_level_hi
                                               : !st_reg.out_level_hi;             // [R15]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg          <= '0;
      st_reg.fset     <= tio_pkg::FSET_RST;
      st_reg.cmd.fset <= tio_pkg::FSET_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = st_reg.rdata;
  assign trig_out_o = st_reg.pin;
  assign cmd_o      = st_reg.cmd;

  // checks
  localparam int FIRE_LO = 1;
  localparam int FIRE_HI = 2;

  chk_test_mode_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(test_mode_i) |-> !(cmd_o.out_set || cmd_o.sp_apply || cmd_o.pre_load ||
                             cmd_o.transient_event_action)) // [R1]
    else $error("action issued in test mode");

  chk_pin_high_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_pulse |-> $past(in_level)) // [R2]
    else $error("trigger qualified while pin low");

  chk_none_no_act: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_pulse && st_reg.in_action == tio_pkg::TIO_ACT_NONE) |=> !cmd_o.out_set &&
      !cmd_o.sp_apply && !cmd_o.pre_load && !cmd_o.transient_event_action) // [R3]
    else $error("action taken with action none");

  chk_output_state: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_pulse && !test_mode_i && st_reg.in_action == tio_pkg::TIO_ACT_OUTPUT)
      |=> cmd_o.out_set && cmd_o.out_state == $past(st_reg.in_state)) // [R4]
    else $error("output action wrong");

  chk_fset_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_o.sp_apply |-> cmd_o.fset >= tio_pkg::FSET_MIN && cmd_o.fset <= tio_pkg::FSET_MAX) // [R5]
    else $error("frequency setpoint out of range");

  chk_slot_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_o.pre_load |-> cmd_o.slot <= tio_pkg::SLOT_MAX) // [R6]
    else $error("preset slot out of range");

  chk_trans_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (in_pulse && !test_mode_i && st_reg.in_action == tio_pkg::TIO_ACT_TRANS)
      |-> ##[FIRE_LO:FIRE_HI] cmd_o.transient_event_action) // [R7]
    else $error("transient request missing");

  chk_src_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_source == tio_pkg::TIO_SRC_NONE && st_reg.out_width != 6'h00 &&
     !trig_out_o && !sw_out_trig) |=> !trig_out_o) // [R9]
    else $error("pin pulsed with source none");

  chk_pulse_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_level && st_reg.out_width != 6'h00) |=> trig_out_o [*2]) // [R14]
    else $error("output pulse did not start");

  chk_pulse_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (src_level && st_reg.pulse_on && st_reg.out_width != 6'h00)
      |=> st_reg.pulse_ms == $past(st_reg.out_width)) // [R17]
    else $error("pulse not restarted");

  chk_static_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_width == 6'h00 && st_next.out_width == 6'h00 && src_level)
      |=> trig_out_o == $past(st_reg.out_level_hi)) // [R15]
    else $error("static level wrong polarity");

  chk_src_output: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_source == tio_pkg::TIO_SRC_OUTPUT && ev_i.output_chg && !test_mode_i &&
     st_reg.out_width != 6'h00) |=> trig_out_o) // [R10]
    else $error("output change did not fire pin");

  chk_src_setting: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_source == tio_pkg::TIO_SRC_SETTING && ev_i.setting_chg && !test_mode_i &&
     st_reg.out_width != 6'h00) |=> trig_out_o) // [R11]
    else $error("setting change did not fire pin");

  chk_src_preset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_source == tio_pkg::TIO_SRC_PRESET && (ev_i.preset_load || ev_i.preset_save) &&
     !test_mode_i && st_reg.out_width != 6'h00) |=> trig_out_o) // [R12]
    else $error("preset event did not fire pin");

  chk_src_all: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_source == tio_pkg::TIO_SRC_ALL && (|ev_i) && !test_mode_i &&
     st_reg.out_width != 6'h00) |=> trig_out_o) // [R13]
    else $error("event did not fire pin with source all");

  // polarity must not leak into pulse mode: idle stays low whatever the level bit
  chk_pulse_idle_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.out_width != 6'h00 && !st_reg.pulse_on && !src_level && !sw_out_trig)
      |=> !trig_out_o) // [R16]
    else $error("pin not low between pulses");

  // level may only rise after the pin stood high in stages two and three
  chk_in_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(in_level) |-> $past(trig_in_i, 3) && $past(trig_in_i, 4)) // [R18]
    else $error("input level rose without a settled high pin");

  cov_in_action: cover property (@(posedge clk_i) disable iff (!rst_n_i) in_pulse);
  cov_out_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.pulse_on ##1 !st_reg.pulse_on);
  cov_restart:   cover property (@(posedge clk_i) disable iff (!rst_n_i)
    src_level && st_reg.pulse_on);
  cov_static:    cover property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg.out_width == 6'h00 && src_level);
endmodule : tio_trigger_io

// *** tio_ext_equip.sv ***
`timescale 1ns/10ps
module tio_ext_equip (
  input  wire logic clk_i,      // system clock
  input  wire logic trig_out_i, // watched trigger output
  output logic      trig_in_o   // driven trigger input
);
  int unsigned run_len  = 0; // cycles high so far
  int unsigned last_len = 0; // length of last completed high
  int unsigned n_high   = 0; // completed highs
  initial trig_in_o = 1'b0;
  // measure each high stretch, as a watching instrument would
  always @(posedge clk_i) begin
    if (trig_out_i === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      n_high   <= n_high + 1;
      run_len  <= 0;
    end
  end
  // idle low; a trigger is the pin held high for a while
  task automatic pulse(input int unsigned cyc);
    trig_in_o <= 1'b1;
    repeat (cyc) @(posedge clk_i);
    trig_in_o <= 1'b0;
  endtask : pulse
endmodule : tio_ext_equip

// *** testbench.sv ***
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
  localparam int unsigned MSC = 10; // short ms keeps the run small
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = 32'h0;
  wire logic         hready;
  logic              hreadyout;
  logic [31:0]       hrdata;
  logic              hresp;
  logic              trig_in_i;
  logic              trig_out_o;
  logic              test_mode_i = 1'b0;
  tio_pkg::tio_ev_t  ev_i = '0;
  tio_pkg::tio_cmd_t cmd_o;
  logic [4:0]        seen = '0;
  logic              clr = 1'b0;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  logic [31:0]       d;

  always #50 clk_i = ~clk_i;
  assign hready = hreadyout; // single slave drives the bus ready

  tio_trigger_io #(.MS_CYCLES(MSC)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .trig_in_i(trig_in_i), .trig_out_o(trig_out_o), .test_mode_i(test_mode_i),
    .ev_i(ev_i), .cmd_o(cmd_o));
  tio_ext_equip ext_eq (.clk_i(clk_i), .trig_out_i(trig_out_o), .trig_in_o(trig_in_i));

  // sticky record of action strobes, since each stands one cycle only
  always @(posedge clk_i) begin
    seen <= clr ? 5'h00 : seen | {cmd_o.transient_event_action, cmd_o.pre_load,
                                  cmd_o.sp_apply, cmd_o.out_set, cmd_o.remote_trig};
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("mismatches %0d, comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // one single ahb transfer, whole word
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= tio_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // hi of 0 means a remote input trigger instead of a pin pulse
  task automatic in_case(input logic [31:0] cfg, input int unsigned hi, input logic [4:0] ex);
    logic [31:0] r;
    bus(1'b1, tio_pkg::OFS_IN_CFG, cfg, r);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    if (hi == 0) begin
      bus(1'b1, tio_pkg::OFS_CMD_STAT, 32'h1, r);
    end else begin
      ext_eq.pulse(hi);
    end
    repeat (3 * MSC) @(posedge clk_i);
    `CHK("input action", ex, seen)
  endtask : in_case

  // hold of 0 means a remote output trigger; gap re-fires the event mid-pulse
  task automatic out_case(input logic [31:0] cfg, input logic [3:0] ev, input int unsigned hold,
                          input int unsigned gap, input int unsigned ex);
    int unsigned n0;
    logic [31:0] r;
    bus(1'b1, tio_pkg::OFS_OUT_CFG, cfg, r);
    repeat (3) @(posedge clk_i); // a static level left by the old mode ends here, not counted
    n0 = ext_eq.n_high;
    if (hold == 0) begin
      bus(1'b1, tio_pkg::OFS_CMD_STAT, 32'h2, r);
    end else begin
      ev_i <= ev;
      repeat (hold) @(posedge clk_i);
      ev_i <= '0;
    end
    if (gap != 0) begin
      repeat (gap - 1) @(posedge clk_i);
      ev_i <= ev;
      @(posedge clk_i);
      ev_i <= '0;
    end
    repeat (ex + 5 * MSC) @(posedge clk_i); // long pulses must end before counting
    `CHK("pulse count", int'(ex != 0), ext_eq.n_high - n0)
    if (ex != 0) `CHK("pulse length", ex, ext_eq.last_len)
  endtask : out_case

  // static low polarity idles high and drops while the source holds
  task automatic static_low();
    logic [31:0] r;
    bus(1'b1, tio_pkg::OFS_OUT_CFG, 32'h0000_0001, r);
    repeat (3) @(posedge clk_i);
    `CHK("idle level", 1'b1, trig_out_o)
    bus(1'b0, tio_pkg::OFS_CMD_STAT, 32'h0, r);
    `CHK("out status", 1'b1, r[tio_pkg::ST_OUT_BIT])
    ev_i <= 4'h8;
    repeat (3) @(posedge clk_i);
    `CHK("active level", 1'b0, trig_out_o)
    ev_i <= '0;
    test_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("test mode level", 1'b0, trig_out_o)
    test_mode_i <= 1'b0;
  endtask : static_low

  function automatic bit hit(input int s, input int b);
    case (s)
      1: hit = (b == 3);
      2: hit = (b == 2);
      3: hit = (b < 2);
      4: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  endfunction : hit

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, tio_pkg::OFS_SETPT, 32'h0, d);
    `CHK("setpoint reset", {tio_pkg::FSET_RST, 16'h0}, d)
    bus(1'b0, 8'h10, 32'h0, d);
    `CHK("unmapped read", 32'h0, d)
    `CHK("response", 1'b0, hresp)
    in_case(32'h0002_0000, 50, 5'h00);
    in_case(32'h0002_0000, 0, 5'h01);
    in_case(32'h0002_0011, 50, 5'h02);
    `CHK("output state", 1'b1, cmd_o.out_state)
    bus(1'b1, tio_pkg::OFS_SETPT, 32'hffff_1234, d);
    in_case(32'h0002_0002, 50, 5'h04);
    `CHK("freq clamp", tio_pkg::FSET_MAX, cmd_o.fset)
    `CHK("voltage", 16'h1234, cmd_o.vset)
    in_case(32'h0002_0c03, 50, 5'h08);
    `CHK("slot clamp", 4'h9, cmd_o.slot)
    in_case(32'h0002_0004, 50, 5'h10);
    in_case(32'h0002_0001, MSC, 5'h00);
    in_case(32'h0000_0001, 4 * MSC, 5'h00);
    in_case(32'h0000_0001, 7 * MSC, 5'h02);
    test_mode_i <= 1'b1;
    in_case(32'h0002_0001, 50, 5'h00);
    bus(1'b0, tio_pkg::OFS_CMD_STAT, 32'h0, d);
    `CHK("test mode status", 1'b1, d[tio_pkg::ST_TEST_BIT])
    test_mode_i <= 1'b0;
    for (int s = 0; s < 5; s++) begin
      for (int b = 0; b < 4; b++) begin
        out_case(32'h0000_0110 | s, 4'h1 << b, 1, 0, hit(s, b) ? MSC : 0);
      end
    end
    out_case(32'h0000_0300, 4'h0, 0, 0, 3 * MSC);
    out_case(32'h0000_0301, 4'h8, 1, 15, 15 + 3 * MSC);
    out_case(32'h0000_3c01, 4'h8, 1, 0, 60 * MSC);
    out_case(32'h0000_0011, 4'h8, 7, 0, 7);
    static_low();
    finish_test();
  end
endmodule : testbench
